// file: include/motion_cfg.svh
/*
 constants of the motion mode sequencer: parameter addresses,
 reset values, status bit positions.
 assumes inclusion by bare name from the modules.
*/
// Behaviour
// - each jog start moves one inching distance
// - jog start withdrawn: stop motor at once
// - inching distance 16 bit, default 20, min 1
// - slow 60 and fast 180 manual speeds
// - speed mode runs without end position
// - speed setpoint write enters speed mode
// - speed mode ends at zero speeds or fault
// - speed status bits 13 14 15
// - error bits 0 1 2 3 5 6 7
// - new speed accepted while moving
// - no area limits in speed mode
// - ramps latched on setpoint write
// - absolute from zero, relative from position
// - target write enters ptp at stored speed
// - ptp ends at target standstill or fault
// - start word: bit0 pos, bit1 neg, bit2 fast
// - ptp status bits 13 14 15, same errors
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH
`define IDX_MANUAL     8'h29
`define IDX_VEL        8'h24
`define IDX_PTP        8'h23
`define SIDX_START     8'h01
`define SIDX_MSTAT     8'h02
`define SIDX_SLOW      8'h04
`define SIDX_FAST      8'h05
`define SIDX_DIST      8'h06
`define SIDX_VSET      8'h01
`define SIDX_VSTAT     8'h02
`define SIDX_PABS      8'h01
`define SIDX_PSTAT     8'h02
`define SIDX_PREL      8'h03
`define SIDX_PSPD      8'h05
`define RST_SLOW       32'h0000003c
`define RST_FAST       32'h000000b4
`define RST_DIST       16'h0014
`define BIT_DIR_POS    0
`define BIT_DIR_NEG    1
`define BIT_FAST       2
`define BIT_REACHED    13
`define BIT_END        14
`define BIT_ERR        15
`define ERR_USED_MASK  8'hef
`define ERR_AREA_MASK  8'h60
`endif

// file: include/motion_pkg.sv
/*
 types of the motion mode sequencer.
 assumes motion_cfg.svh holds the numeric constants.
*/
`default_nettype none
package motion_pkg;
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_INCH,
        MODE_VEL,
        MODE_PTP
    } mode_t;
    typedef logic signed [31:0] word_t;
endpackage : motion_pkg
`default_nettype wire

// file: hw/mode_status_word.sv
/*
 one acknowledgement word of an operating mode.
 assumes clear, done and abort are single cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "motion_cfg.svh"
module mode_status_word (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clear,   // new start of the mode
    input  wire logic [7:0]  fault,   // errors seen by the mode
    input  wire logic        reached, // setpoint reached level
    input  wire logic        done,    // mode finished pulse
    input  wire logic        abort,   // finished by fault pulse
    output logic      [15:0] word
);
    logic [15:0] word_q;   // acknowledgement register
    logic [15:0] word_d;
    logic [15:0] sets;     // bits set this cycle

    // sets beat the clear so no event is lost on restart
    always_comb begin
        sets = 16'h0000;
        sets[7:0] = fault & `ERR_USED_MASK;
        sets[`BIT_END] = done | abort;
        sets[`BIT_ERR] = abort;
        if (clear) begin
            word_d = sets;
        end else begin
            word_d = word_q | sets;
        end
        // reached holds until the next start so it still reads set
        // beside the end flag once the mode has finished
        word_d[`BIT_REACHED] = ~clear & (reached | word_q[`BIT_REACHED]);
    end

    // register only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_q <= 16'h0000;
        end else begin
            word_q <= word_d;
        end
    end

    assign word = word_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    end_sticky_a: assert property (
        done |=> word_q[`BIT_END]
        ##1 (word_q[`BIT_END] || $past(clear)))
        else $error("end flag lost");
    err_tie_a: assert property (
        word_q[`BIT_ERR] |-> word_q[`BIT_END])
        else $error("error flag without end flag");
    reserved_a: assert property (
        word_q[12:8] == 5'h00 && !word_q[4])
        else $error("reserved status bit set");
endmodule : mode_status_word
`default_nettype wire

// file: hw/motion_mode_sequencer.sv
/*
 operating mode sequencer: unified inching, speed mode and
 point-to-point positioning, driven by index:subindex parameter access.
 assumes the profile generator shares CLK_SYS and feeds actual
 position and speed; fault lines are pins and are synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
`include "motion_cfg.svh"
module motion_mode_sequencer (
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        PAR_WR,        // parameter write strobe
    input  wire logic        PAR_RD,        // parameter read strobe
    input  wire logic [7:0]  PAR_IDX,       // parameter index
    input  wire logic [7:0]  PAR_SIDX,      // parameter subindex
    input  wire logic [31:0] PAR_WDATA,     // write value
    output logic      [31:0] PAR_RDATA,     // read value
    output logic             PAR_ACK,       // answer pulse
    output logic             PAR_ERR,       // refused with answer
    input  wire logic [31:0] ACT_POS,       // actual position
    input  wire logic [31:0] ACT_SPEED,     // actual speed
    input  wire logic [31:0] RAMP_ACC_IN,   // ramp settings in
    input  wire logic [31:0] RAMP_DEC_IN,
    input  wire logic        POSITIVE_LIMIT_ERROR,
    input  wire logic        NEGATIVE_LIMIT_ERROR,
    input  wire logic        HARDWARE_STOP_ERROR,
    input  wire logic        REFERENCE_ERROR,
    input  wire logic        SOFT_POSITIVE_LIMIT_ERROR,
    input  wire logic        SOFT_NEGATIVE_LIMIT_ERROR,
    input  wire logic        SOFT_STOP_ERROR,
    output logic [31:0]      TARGET_SPEED,  // to profile generator
    output logic [31:0]      TARGET_POS,
    output logic             POS_CONTROL,   // 1 position, 0 speed
    output logic             STOP_NOW,      // brake at once
    output logic [31:0]      RAMP_ACC,      // latched ramps
    output logic [31:0]      RAMP_DEC,
    output logic [1:0]       MODE
);
    // decode of one parameter address, used by read and write
    function automatic logic hit(input logic [7:0] idx,
                                 input logic [7:0] sidx,
                                 input logic [7:0] ci,
                                 input logic [7:0] cs);
        hit = (idx == ci) && (sidx == cs);
    endfunction : hit

    // fault pins: two flops before any use
    logic [7:0] flt_meta_q;   // first stage, read by second only
    logic [7:0] flt_q;        // synchronised faults
    logic [7:0] flt_pin;
    assign flt_pin = {SOFT_STOP_ERROR, SOFT_NEGATIVE_LIMIT_ERROR,
                      SOFT_POSITIVE_LIMIT_ERROR, 1'b0,
                      REFERENCE_ERROR, HARDWARE_STOP_ERROR,
                      NEGATIVE_LIMIT_ERROR, POSITIVE_LIMIT_ERROR};
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            flt_meta_q <= 8'h00;
            flt_q      <= 8'h00;
        end else begin
            flt_meta_q <= flt_pin;
            flt_q      <= flt_meta_q;
        end
    end

    // settings
    logic [31:0] slow_q, slow_d;       // manual_slow_speed
    logic [31:0] fast_q, fast_d;       // manual_fast_speed
    logic [15:0] dist_q, dist_d;       // inching_distance
    logic [31:0] vset_q, vset_d;       // speed_setpoint
    logic [31:0] pabs_q, pabs_d;       // absolute_target
    logic [31:0] prel_q, prel_d;       // relative_target
    logic [31:0] pspd_q, pspd_d;       // ptp_target_speed
    logic [2:0]  cmd_q, cmd_d;         // manual_start_command
    // motion state
    motion_pkg::mode_t mode_q, mode_d;
    logic [31:0] tspd_q, tspd_d;
    logic [31:0] tpos_q, tpos_d;
    logic        posc_q, posc_d;
    logic        stop_q, stop_d;
    logic [31:0] acc_q, acc_d;
    logic [31:0] dec_q, dec_d;
    // answer
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic        err_q, err_d;
    // status word strobes
    logic        clr_m, clr_v, clr_p;  // mode start
    logic        done_m, done_v, done_p;
    logic        abrt_m, abrt_v, abrt_p;
    logic [7:0]  flt_eff;              // faults that count now
    logic        standstill;
    logic        at_target;
    logic [15:0] st_m, st_v, st_p;     // status words
    logic [31:0] pos_step;             // zero-extended inching step

    // the area limits do not reach speed mode
    assign flt_eff = (mode_q == motion_pkg::MODE_VEL) ?
                     (flt_q & ~`ERR_AREA_MASK) : flt_q;
    assign standstill = (ACT_SPEED == 32'h00000000);
    assign at_target  = (ACT_POS == tpos_q);
    assign pos_step   = {16'h0000, dist_q};

    // mode sequencing and parameter access
    always_comb begin
        slow_d = slow_q;
        fast_d = fast_q;
        dist_d = dist_q;
        vset_d = vset_q;
        pabs_d = pabs_q;
        prel_d = prel_q;
        pspd_d = pspd_q;
        cmd_d  = cmd_q;
        mode_d = mode_q;
        tspd_d = tspd_q;
        tpos_d = tpos_q;
        posc_d = posc_q;
        stop_d = stop_q;
        acc_d  = acc_q;
        dec_d  = dec_q;
        ack_d  = PAR_WR | PAR_RD;
        err_d  = 1'b0;
        rdata_d = rdata_q;
        {clr_m, clr_v, clr_p} = 3'b000;
        {done_m, done_v, done_p} = 3'b000;
        {abrt_m, abrt_v, abrt_p} = 3'b000;
        // brake request ends once the axis is still; the target
        // follows the stop point so the axis does not move off again
        if (stop_q && standstill) begin
            stop_d = 1'b0;
            tspd_d = 32'h0;
            tpos_d = ACT_POS;
        end
        // completion and fault response of the running mode
        case (mode_q)
            motion_pkg::MODE_IDLE: begin
            end
            motion_pkg::MODE_INCH: begin
                if (|flt_eff) begin
                    abrt_m = 1'b1;
                end else if (standstill &&
                             (at_target || stop_q)) begin
                    done_m = 1'b1;
                end
            end
            motion_pkg::MODE_VEL: begin
                if (|flt_eff) begin
                    abrt_v = 1'b1;
                end else if (standstill && tspd_q == 32'h0) begin
                    done_v = 1'b1;
                end
            end
            motion_pkg::MODE_PTP: begin
                if (|flt_eff) begin
                    abrt_p = 1'b1;
                end else if (standstill && at_target) begin
                    done_p = 1'b1;
                end
            end
            default: begin
                mode_d = motion_pkg::MODE_IDLE;
            end
        endcase
        if (abrt_m | abrt_v | abrt_p) begin
            tspd_d = 32'h0;
            stop_d = 1'b1;
            mode_d = motion_pkg::MODE_IDLE;
        end else if (done_m | done_v | done_p) begin
            mode_d = motion_pkg::MODE_IDLE;
        end
        // parameter writes; a new start wins over completion
        if (PAR_WR) begin
            if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL, `SIDX_START)) begin
                cmd_d = PAR_WDATA[2:0];
                if (PAR_WDATA[`BIT_DIR_POS] ^ PAR_WDATA[`BIT_DIR_NEG])
                begin
                    // one jog per start, from the current spot
                    mode_d = motion_pkg::MODE_INCH;
                    clr_m  = 1'b1;
                    posc_d = 1'b1;
                    stop_d = 1'b0;
                    tpos_d = PAR_WDATA[`BIT_DIR_POS] ?
                             32'(ACT_POS + pos_step) :
                             32'(ACT_POS - pos_step);
                    tspd_d = PAR_WDATA[`BIT_FAST] ? fast_q
                                                  : slow_q;
                end else if (PAR_WDATA[1:0] == 2'b00 &&
                             mode_q == motion_pkg::MODE_INCH) begin
                    // withdrawn before target: brake now
                    tspd_d = 32'h0;
                    stop_d = 1'b1;
                    mode_d = motion_pkg::MODE_INCH;
                end else if (PAR_WDATA[1:0] == 2'b11) begin
                    err_d = 1'b1; // both senses at once: refused
                end
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_SLOW)) begin
                slow_d = PAR_WDATA;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_FAST)) begin
                fast_d = PAR_WDATA;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_DIST)) begin
                if (PAR_WDATA[15:0] == 16'h0000) begin
                    err_d = 1'b1;
                end else begin
                    dist_d = PAR_WDATA[15:0];
                end
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_VEL,
                             `SIDX_VSET)) begin
                // taken even in motion; zero brakes on the ramp
                vset_d = PAR_WDATA;
                tspd_d = PAR_WDATA;
                mode_d = motion_pkg::MODE_VEL;
                posc_d = 1'b0;
                stop_d = 1'b0;
                clr_v  = 1'b1;
                acc_d  = RAMP_ACC_IN;
                dec_d  = RAMP_DEC_IN;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_PTP, `SIDX_PABS) ||
                         hit(PAR_IDX, PAR_SIDX, `IDX_PTP, `SIDX_PREL))
            begin
                // absolute needs a referenced axis, the host's duty
                if (PAR_SIDX == `SIDX_PABS) begin
                    pabs_d = PAR_WDATA;
                    tpos_d = PAR_WDATA;
                end else begin
                    // relative to the spot where the axis stands
                    prel_d = PAR_WDATA;
                    tpos_d = 32'(ACT_POS + PAR_WDATA);
                end
                mode_d = motion_pkg::MODE_PTP;
                tspd_d = pspd_q;
                posc_d = 1'b1;
                stop_d = 1'b0;
                clr_p  = 1'b1;
                acc_d  = RAMP_ACC_IN;
                dec_d  = RAMP_DEC_IN;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_PTP,
                             `SIDX_PSPD)) begin
                pspd_d = PAR_WDATA;
            end else begin
                err_d = 1'b1; // unmapped or read only
            end
        end
        // reads: unmapped answers zero with the error flag
        if (PAR_RD) begin
            rdata_d = 32'h0;
            if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL, `SIDX_START)) begin
                rdata_d = {29'h0, cmd_q};
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_MSTAT)) begin
                rdata_d = {16'h0, st_m};
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_SLOW)) begin
                rdata_d = slow_q;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_FAST)) begin
                rdata_d = fast_q;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL,
                             `SIDX_DIST)) begin
                rdata_d = {16'h0, dist_q};
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_VEL,
                             `SIDX_VSET)) begin
                rdata_d = vset_q;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_VEL,
                             `SIDX_VSTAT)) begin
                rdata_d = {16'h0, st_v};
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_PTP,
                             `SIDX_PABS)) begin
                rdata_d = pabs_q;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_PTP,
                             `SIDX_PSTAT)) begin
                rdata_d = {16'h0, st_p};
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_PTP,
                             `SIDX_PREL)) begin
                rdata_d = prel_q;
            end else if (hit(PAR_IDX, PAR_SIDX, `IDX_PTP,
                             `SIDX_PSPD)) begin
                rdata_d = pspd_q;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    // register only
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            slow_q  <= `RST_SLOW;
            fast_q  <= `RST_FAST;
            dist_q  <= `RST_DIST;
            vset_q  <= 32'h0;
            pabs_q  <= 32'h0;
            prel_q  <= 32'h0;
            pspd_q  <= 32'h0;
            cmd_q   <= 3'h0;
            mode_q  <= motion_pkg::MODE_IDLE;
            tspd_q  <= 32'h0;
            tpos_q  <= 32'h0;
            posc_q  <= 1'b0;
            stop_q  <= 1'b0;
            acc_q   <= 32'h0;
            dec_q   <= 32'h0;
            rdata_q <= 32'h0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            slow_q  <= slow_d;
            fast_q  <= fast_d;
            dist_q  <= dist_d;
            vset_q  <= vset_d;
            pabs_q  <= pabs_d;
            prel_q  <= prel_d;
            pspd_q  <= pspd_d;
            cmd_q   <= cmd_d;
            mode_q  <= mode_d;
            tspd_q  <= tspd_d;
            tpos_q  <= tpos_d;
            posc_q  <= posc_d;
            stop_q  <= stop_d;
            acc_q   <= acc_d;
            dec_q   <= dec_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
        end
    end

    // status words, errors only while the mode runs
    mode_status_word u_stat_man (
        .clk(CLK_SYS), .rst_n(RESETN), .clear(clr_m),
        .fault(mode_q == motion_pkg::MODE_INCH ? flt_eff : 8'h00),
        .reached(1'b0), .done(done_m), .abort(abrt_m), .word(st_m));
    mode_status_word u_stat_vel (
        .clk(CLK_SYS), .rst_n(RESETN), .clear(clr_v),
        .fault(mode_q == motion_pkg::MODE_VEL ? flt_eff : 8'h00),
        .reached(mode_q == motion_pkg::MODE_VEL &&
                 ACT_SPEED == tspd_q),
        .done(done_v), .abort(abrt_v), .word(st_v));
    mode_status_word u_stat_ptp (
        .clk(CLK_SYS), .rst_n(RESETN), .clear(clr_p),
        .fault(mode_q == motion_pkg::MODE_PTP ? flt_eff : 8'h00),
        .reached(mode_q == motion_pkg::MODE_PTP && at_target),
        .done(done_p), .abort(abrt_p), .word(st_p));

    assign PAR_RDATA    = rdata_q;
    assign PAR_ACK      = ack_q;
    assign PAR_ERR      = err_q;
    assign TARGET_SPEED = tspd_q;
    assign TARGET_POS   = tpos_q;
    assign POS_CONTROL  = posc_q;
    assign STOP_NOW     = stop_q;
    assign RAMP_ACC     = acc_q;
    assign RAMP_DEC     = dec_q;
    assign MODE         = mode_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    logic wr_vel;
    logic wr_start;
    assign wr_vel = PAR_WR && hit(PAR_IDX, PAR_SIDX, `IDX_VEL, `SIDX_VSET);
    assign wr_start = PAR_WR &&
                      hit(PAR_IDX, PAR_SIDX, `IDX_MANUAL, `SIDX_START);
    vel_start_a: assert property (wr_vel |=>
        mode_q == motion_pkg::MODE_VEL && tspd_q == $past(PAR_WDATA))
        else $error("speed write did not start speed mode");
    ramp_latch_a: assert property ($changed(acc_q) |->
        $past(PAR_WR) && $past(PAR_IDX) != `IDX_MANUAL)
        else $error("ramp changed without setpoint write");
    inch_target_a: assert property (
        wr_start && PAR_WDATA[1:0] == 2'b01
        |=> tpos_q == 32'($past(ACT_POS) + $past(pos_step)))
        else $error("inching target wrong");
    inch_stop_a: assert property (
        wr_start && PAR_WDATA[1:0] == 2'b00 &&
        mode_q == motion_pkg::MODE_INCH |=> stop_q && tspd_q == 32'h0)
        else $error("withdrawn jog not stopped");
    dist_min_a: assert property (dist_q != 16'h0000)
        else $error("inching distance zero");
    fast_sel_a: assert property (
        wr_start && PAR_WDATA[2:0] == 3'b110 |=> tspd_q == fast_q)
        else $error("fast jog speed not used");
    ptp_rel_a: assert property (
        PAR_WR && hit(PAR_IDX, PAR_SIDX, `IDX_PTP, `SIDX_PREL) |=>
        tpos_q == 32'($past(ACT_POS) + $past(PAR_WDATA)) &&
        tspd_q == $past(pspd_q))
        else $error("relative target wrong");
    vel_area_a: assert property (
        mode_q == motion_pkg::MODE_VEL &&
        (flt_q & ~`ERR_AREA_MASK) == 8'h00 && !PAR_WR |=>
        mode_q == motion_pkg::MODE_VEL || $past(done_v))
        else $error("area limit stopped speed mode");
    fault_stop_a: assert property (
        mode_q != motion_pkg::MODE_IDLE && |flt_eff && !PAR_WR
        |=> stop_q && tspd_q == 32'h0)
        else $error("fault did not stop motion");
    inch_cv: cover property (wr_start ##[1:50] done_m);
    vel_cv: cover property (wr_vel ##[1:50] abrt_v);
    ptp_cv: cover property (clr_p ##[1:50] done_p);
endmodule : motion_mode_sequencer
`default_nettype wire

// file: testbench/prof_gen_model.sv
/*
 profile generator model: follows the target position one unit per cycle, the target speed at once.
 assumes the CLK_SYS domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module prof_gen_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] tgt_spd,
    input  wire logic [31:0] tgt_pos,
    input  wire logic        pos_ctl,
    input  wire logic        stop,
    output logic      [31:0] pos_q,
    output logic      [31:0] spd_q
);
    // one unit a cycle keeps every move short
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_q <= 32'h0;
            spd_q <= 32'h0;
        end else if (stop) begin
            spd_q <= 32'h0;
        end else if (pos_ctl && pos_q != tgt_pos) begin
            spd_q <= 32'h1;
            pos_q <= ($signed(tgt_pos - pos_q) > 0) ? pos_q + 1 : pos_q - 1;
        end else begin
            spd_q <= pos_ctl ? 32'h0 : tgt_spd;
        end
    end
endmodule : prof_gen_model
`default_nettype wire

// file: testbench/motion_mode_sequencer_tb.sv
/*
 self-checking bench of the mode sequencer with random values.
 assumes prof_gen_model stands in for the profile generator.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_mode_sequencer_tb;
    logic clk, rst_n, wr, rd, ack, err, pctl, stp;
    logic [7:0] idx, sidx;
    logic [6:0] flt;
    logic [1:0] mode;
    logic [31:0] wd, rdat, acc, dec, tsp, tps, racc, rdec, apos, aspd;
    logic [31:0] r, p0, d, v;
    int n_errors, n_checks;
    motion_mode_sequencer dut_u (.CLK_SYS(clk), .RESETN(rst_n),
        .PAR_WR(wr), .PAR_RD(rd), .PAR_IDX(idx), .PAR_SIDX(sidx),
        .PAR_WDATA(wd), .PAR_RDATA(rdat), .PAR_ACK(ack), .PAR_ERR(err),
        .ACT_POS(apos), .ACT_SPEED(aspd), .RAMP_ACC_IN(acc),
        .RAMP_DEC_IN(dec), .POSITIVE_LIMIT_ERROR(flt[0]),
        .NEGATIVE_LIMIT_ERROR(flt[1]), .HARDWARE_STOP_ERROR(flt[2]),
        .REFERENCE_ERROR(flt[3]), .SOFT_POSITIVE_LIMIT_ERROR(flt[4]),
        .SOFT_NEGATIVE_LIMIT_ERROR(flt[5]), .SOFT_STOP_ERROR(flt[6]),
        .TARGET_SPEED(tsp), .TARGET_POS(tps), .POS_CONTROL(pctl),
        .STOP_NOW(stp), .RAMP_ACC(racc), .RAMP_DEC(rdec), .MODE(mode));
    prof_gen_model pg_u (.clk(clk), .rst_n(rst_n), .tgt_spd(tsp),
        .tgt_pos(tps), .pos_ctl(pctl), .stop(stp), .pos_q(apos),
        .spd_q(aspd));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // expected error field: bit 4 is unused
    function automatic logic [31:0] exp_err(input logic [6:0] f);
        return {16'h0, 8'hc0, f[6:4], 1'b0, f[3:0]};
    endfunction : exp_err
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // one parameter access, answer sampled one cycle on
    task automatic xfer(input logic w, input logic [7:0] i,
                        input logic [7:0] s, input logic [31:0] dt,
                        input logic e);
        @(negedge clk);
        {wr, rd, idx, sidx, wd, p0} = {w, !w, i, s, dt, apos};
        @(negedge clk);
        {wr, rd} = 2'h0;
        chk({31'h0, ack}, 32'h1);
        chk({31'h0, err}, {31'h0, e});
    endtask : xfer
    // bounded wait for idle, plus room for the status update
    task automatic wait_idle();
        int k;
        for (k = 0; k < 3000 && mode !== 2'h0; k++) @(negedge clk);
        if (k == 3000) chk({30'h0, mode}, 32'h0);
        if (k == 3000) close_out();
        repeat (2) @(negedge clk);
    endtask : wait_idle
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        {r, rst_n, wr, rd, idx, sidx, wd, flt, acc, dec} = {32'h3d, 122'h0};
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        xfer(1'h0, 8'h29, 8'h04, 32'h0, 1'h0);
        chk(rdat, 32'h3c);
        xfer(1'h0, 8'h29, 8'h05, 32'h0, 1'h0);
        chk(rdat, 32'hb4);
        xfer(1'h1, 8'h29, 8'h06, 32'h0, 1'h1);
        xfer(1'h0, 8'h29, 8'h06, 32'h0, 1'h0);
        chk(rdat, 32'h14);
        xfer(1'h0, 8'h55, 8'h00, 32'h0, 1'h1);
        chk(rdat, 32'h0);
        // every direction and speed, random distance
        for (int j = 0; j < 4; j++) begin
            r = nx(r);
            d = {28'h0, r[3:0]} + 1;
            xfer(1'h1, 8'h29, 8'h06, d, 1'h0);
            xfer(1'h1, 8'h29, 8'h01, {29'h0, j[1], j[0], ~j[0]}, 1'h0);
            chk(tps, j[0] ? p0 - d : p0 + d);
            chk(tsp, j[1] ? 32'hb4 : 32'h3c);
            wait_idle();
            chk(apos, tps);
        end
        xfer(1'h1, 8'h29, 8'h06, 32'hffff, 1'h0);
        xfer(1'h1, 8'h29, 8'h01, 32'h1, 1'h0);
        repeat (3) @(negedge clk);
        xfer(1'h1, 8'h29, 8'h01, 32'h0, 1'h0);
        chk({stp, tsp[30:0]}, 32'h80000000);
        wait_idle();
        r = nx(r);
        {acc, dec, v} = {r, ~r, 24'h0, r[7:0] | 8'h01};
        xfer(1'h1, 8'h24, 8'h01, v, 1'h0);
        chk(tsp ^ racc ^ rdec ^ {30'h0, mode}, v ^ 32'hfffffffd);
        {acc, flt} = {32'h0, 7'h30};
        repeat (6) @(negedge clk);
        chk(racc ^ {30'h0, mode}, r ^ 32'h2);
        flt = 7'h0;
        xfer(1'h1, 8'h24, 8'h01, v + 5, 1'h0);
        chk(tsp, v + 5);
        repeat (3) @(negedge clk);
        xfer(1'h0, 8'h24, 8'h02, 32'h0, 1'h0);
        chk({31'h0, rdat[13]}, 32'h1);
        xfer(1'h1, 8'h24, 8'h01, 32'h0, 1'h0);
        wait_idle();
        xfer(1'h0, 8'h24, 8'h02, 32'h0, 1'h0);
        chk({30'h0, rdat[15:14]}, 32'h1);
        // hardware stop ends speed mode with error, reached kept
        xfer(1'h1, 8'h24, 8'h01, v, 1'h0);
        flt = 7'h4;
        wait_idle();
        flt = 7'h0;
        repeat (4) @(negedge clk);
        xfer(1'h0, 8'h24, 8'h02, 32'h0, 1'h0);
        chk(rdat, exp_err(7'h4) | 32'h2000);
        // axis zero at reset stands as the reference point
        xfer(1'h1, 8'h23, 8'h05, v, 1'h0);
        xfer(1'h1, 8'h23, 8'h01, {24'h0, r[15:8]}, 1'h0);
        chk(tps ^ tsp, {24'h0, r[15:8]} ^ v);
        wait_idle();
        xfer(1'h0, 8'h23, 8'h02, 32'h0, 1'h0);
        chk({29'h0, rdat[15:13]}, 32'h3);
        // each fault line aborts a relative move with its error bit
        for (int i = 0; i < 7; i++) begin
            xfer(1'h1, 8'h23, 8'h03, 32'h40, 1'h0);
            chk(tps, p0 + 32'h40);
            flt = 7'h1 << i;
            wait_idle();
            flt = 7'h0;
            repeat (4) @(negedge clk);
            xfer(1'h0, 8'h23, 8'h02, 32'h0, 1'h0);
            chk(rdat, exp_err(7'h1 << i));
        end
        close_out();
    end
endmodule : motion_mode_sequencer_tb
`default_nettype wire
